/* hw/pfw_guard.sv */
// Purpose: write guard and control registers for self-programming flash
// Assumes: flash array answers each request with flash_done
// Notes:   serial programming path enters on sp_* ports
`timescale 1ns/1ps
module pfw_guard import pfw_pkg::*; #(
   parameter int PUD_COUNT  = PUD_CYCLES,
   parameter int ADDR_W     = 13
) (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // protection settings
   input  wire logic              code_protect,
   input  wire logic              wp_hit,
   // serial programming path
   input  wire logic              sp_mod_req,
   output logic                   sp_mod_grant,
   output logic                   sp_mod_refused,
   // flash array
   output logic                   flash_req,
   output logic [1:0]             flash_op,
   output logic                   flash_cfg,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic [13:0]            flash_wdata,
   input  wire logic              flash_done,
   input  wire logic [13:0]       flash_rdata
);
   // address high register carries bits above 8, so at least 9 and at most 16 bits
   if (ADDR_W < 9 || ADDR_W > 16 || PUD_COUNT < 1) begin : g_bad_param
      $error("pfw_guard: bad parameter");
   end

   logic [31:0]       pud_cnt_q;
   logic              pud_busy_q;
   logic              prog_en_q, free_q, latch_only_q, cfg_sel_q, wr_q, rd_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0]        dlow_q;
   logic [5:0]        dhigh_q;
   logic              aw_q, w_q;
   logic [7:0]        awaddr_q;
   logic [31:0]       wdata_q;
   logic              do_wr;
   logic              unlocked;
   logic              blocked_q;
   logic              sp_busy_q;

   function automatic logic hits(input logic [7:0] a, input logic [7:0] reg_addr);
      return a[7:2] == reg_addr[7:2];
   endfunction

   // ==========================================
   // power-up delay timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pud_cnt_q  <= 32'h0000_0000;
         pud_busy_q <= 1'b1;
      end else if (pud_busy_q) begin
         pud_cnt_q  <= pud_cnt_q + 32'h0000_0001;
         pud_busy_q <= (pud_cnt_q < 32'(PUD_COUNT - 1));
      end
   end

   // ==========================================
   // axi write channel: addr and data taken in either order
   assign do_wr = aw_q && w_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q          <= 1'b0;
         w_q           <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
         end
         if (do_wr) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q > ADDR_STATUS) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ==========================================
   // unlock sequence
   pfw_unlock u_unlock (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .key_wr   (do_wr && hits(awaddr_q, ADDR_UNLOCK_KEY)),
      .key_data (wdata_q[7:0]),
      .other_wr (do_wr && !hits(awaddr_q, ADDR_UNLOCK_KEY) && !hits(awaddr_q, ADDR_CONTROL_1)),
      .consume  (do_wr && hits(awaddr_q, ADDR_CONTROL_1)),
      .unlocked (unlocked)
   );

   // ==========================================
   // control register and flash request
   logic wr_go;
   // write protection deliberately not consulted on the cpu path
   assign wr_go = do_wr && hits(awaddr_q, ADDR_CONTROL_1) && wdata_q[BIT_WR] && !wr_q && !rd_q
                  && prog_en_q && wdata_q[BIT_PROG_EN] && unlocked && !pud_busy_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prog_en_q    <= 1'b0;
         free_q       <= 1'b0;
         latch_only_q <= 1'b0;
         cfg_sel_q    <= 1'b0;
         wr_q      <= 1'b0;
         rd_q      <= 1'b0;
         blocked_q <= 1'b0;
      end else begin
         if (do_wr && hits(awaddr_q, ADDR_CONTROL_1)) begin
            prog_en_q    <= wdata_q[BIT_PROG_EN];
            latch_only_q <= wdata_q[BIT_LATCH_ONLY];
            cfg_sel_q    <= wdata_q[BIT_CFG_SEL];
            if (!wr_q) free_q <= wdata_q[BIT_FREE];
            blocked_q <= wdata_q[BIT_WR] && !wr_go && !wr_q;
         end
         if (wr_go) begin
            wr_q <= 1'b1;
         end else if (wr_q && flash_done) begin
            wr_q   <= 1'b0;
            free_q <= 1'b0;
         end
         if (do_wr && hits(awaddr_q, ADDR_CONTROL_1) && wdata_q[BIT_RD] && !wr_q && !wr_go) begin
            rd_q <= 1'b1;
         end else if (rd_q && flash_done) begin
            rd_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // address and data registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_q  <= '0;
         dlow_q  <= 8'h00;
         dhigh_q <= 6'h00;
      end else begin
         if (do_wr && hits(awaddr_q, ADDR_ADDR_LOW)) addr_q[7:0] <= wdata_q[7:0];
         if (do_wr && hits(awaddr_q, ADDR_ADDR_HIGH)) addr_q[ADDR_W-1:8] <= wdata_q[ADDR_W-9:0];
         if (do_wr && hits(awaddr_q, ADDR_DATA_LOW)) dlow_q <= wdata_q[7:0];
         if (do_wr && hits(awaddr_q, ADDR_DATA_HIGH)) dhigh_q <= wdata_q[5:0];
         if (rd_q && flash_done) begin
            // data returned as stored, code protection never scrambles it
            dlow_q  <= flash_rdata[7:0];
            dhigh_q <= flash_rdata[13:8];
         end
      end
   end

   // ==========================================
   // flash request outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_req   <= 1'b0;
         flash_op    <= PFW_OP_READ;
         flash_cfg   <= 1'b0;
         flash_addr  <= '0;
         flash_wdata <= 14'h0000;
      end else begin
         flash_req <= (wr_q || rd_q) && !flash_done;
         if (wr_go) begin
            // erase select and latch-only taken from the same word that sets write-go
            flash_op <= wdata_q[BIT_FREE] ? PFW_OP_ERASE
                      : (wdata_q[BIT_LATCH_ONLY] ? PFW_OP_LATCH : PFW_OP_WRITE);
         end else if (!wr_q && !rd_q) begin
            flash_op <= PFW_OP_READ;
         end
         flash_cfg   <= cfg_sel_q;
         flash_addr  <= addr_q;
         flash_wdata <= {dhigh_q, dlow_q};
      end
   end

   // ==========================================
   // serial programming path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sp_mod_grant   <= 1'b0;
         sp_mod_refused <= 1'b0;
         sp_busy_q      <= 1'b0;
      end else begin
         sp_busy_q      <= sp_mod_req;
         sp_mod_grant   <= sp_mod_req && !sp_busy_q && !wp_hit && !pud_busy_q;
         sp_mod_refused <= sp_mod_req && !sp_busy_q && (wp_hit || pud_busy_q);
      end
   end

   // ==========================================
   // axi read channel
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (s_axi_araddr[7:2])
         ADDR_CONTROL_1[7:2]: rd_mux = {24'h000000, 1'b1, cfg_sel_q, latch_only_q, free_q, 1'b0, prog_en_q, wr_q, rd_q};
         ADDR_UNLOCK_KEY[7:2]: rd_mux = 32'h0000_0000;
         ADDR_ADDR_LOW[7:2]:  rd_mux = {24'h000000, addr_q[7:0]};
         ADDR_ADDR_HIGH[7:2]: rd_mux = 32'(addr_q[ADDR_W-1:8]);
         ADDR_DATA_LOW[7:2]:  rd_mux = {24'h000000, dlow_q};
         ADDR_DATA_HIGH[7:2]: rd_mux = {26'h0000000, dhigh_q};
         ADDR_STATUS[7:2]:    rd_mux = {28'h0000000, code_protect, blocked_q, unlocked, pud_busy_q};
         default:             rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (s_axi_araddr > ADDR_STATUS) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

/* hw/pfw_pkg.sv */
// Purpose: constants for the program flash write guard
// Assumes: AXI4-Lite register access, 100 MHz clock
// Notes:   offsets are byte addresses of aligned words
package pfw_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] ADDR_CONTROL_1   = 8'h00;
   localparam logic [7:0] ADDR_UNLOCK_KEY  = 8'h04;
   localparam logic [7:0] ADDR_ADDR_LOW    = 8'h08;
   localparam logic [7:0] ADDR_ADDR_HIGH   = 8'h0C;
   localparam logic [7:0] ADDR_DATA_LOW    = 8'h10;
   localparam logic [7:0] ADDR_DATA_HIGH   = 8'h14;
   localparam logic [7:0] ADDR_STATUS      = 8'h18;
   // ==========================================
   // control register fields
   localparam int BIT_RD     = 0;
   localparam int BIT_WR     = 1;
   localparam int BIT_PROG_EN    = 2;
   localparam int BIT_FREE       = 4;
   localparam int BIT_LATCH_ONLY = 5;
   localparam int BIT_CFG_SEL    = 6;
   localparam int BIT_TOP    = 7;
   // ==========================================
   // unlock keys
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   // ==========================================
   // timing
   localparam int CLK_HZ          = 100_000_000;
   localparam int PUD_MS          = 64;
   localparam int PUD_CYCLES      = CLK_HZ / 1000 * PUD_MS;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ==========================================
   // flash operation codes
   typedef enum logic [1:0] {
      PFW_OP_READ  = 2'h0,
      PFW_OP_ERASE = 2'h1,
      PFW_OP_WRITE = 2'h2,
      PFW_OP_LATCH = 2'h3
   } pfw_op_t;
endpackage

/* hw/pfw_unlock.sv */
// Purpose: unlock key sequence tracker
// Assumes: key_wr pulses once per write to the key port
// Notes:   any other write to any register breaks the sequence
`timescale 1ns/1ps
module pfw_unlock import pfw_pkg::*; (
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // key port writes
   input  wire logic       key_wr,
   input  wire logic [7:0] key_data,
   input  wire logic       other_wr,
   input  wire logic       consume,
   // state
   output logic            unlocked
);
   logic first_q;
   logic unlocked_q;

   // ==========================================
   // ordered pair 55h then AAh
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_q    <= 1'b0;
         unlocked_q <= 1'b0;
      end else if (consume || other_wr) begin
         first_q    <= 1'b0;
         unlocked_q <= 1'b0;
      end else if (key_wr) begin
         first_q    <= (key_data == KEY_FIRST);
         unlocked_q <= first_q && (key_data == KEY_SECOND);
      end
   end

   assign unlocked = unlocked_q;
endmodule

/* bench/pfw_guard_assertions.sv */
// Purpose: port checks for the program flash write guard
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every guard instance
`timescale 1ns/1ps
module pfw_chk import pfw_pkg::*; #(
   parameter int PUD_COUNT  = 20,
   parameter int ADDR_W     = 13
) (
   // clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // register read path
   input wire logic [7:0]        s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic              s_axi_rvalid,
   // serial path and flash side
   input wire logic              wp_hit,
   input wire logic              sp_mod_req,
   input wire logic              sp_mod_grant,
   input wire logic              sp_mod_refused,
   input wire logic              flash_req,
   input wire logic [1:0]        flash_op,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic              flash_done
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================
   // helpers
   int         up_q;
   logic [7:0] ar_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) up_q <= 0;
      else if (up_q < PUD_COUNT) up_q <= up_q + 1;
   end
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
   end
   // ==========================================
   // properties
   // two cycles of slack for the timer's own register stages
   // reads stay allowed during the delay, erase, write and latch are held off
   chk_pud_block: assert property (up_q < PUD_COUNT - 2 |-> !(flash_req && flash_op != PFW_OP_READ))
      else $error("flash request during power-up delay");
   chk_req_hold: assert property (flash_req && !flash_done |=> flash_req && $stable(flash_op) && $stable(flash_addr))
      else $error("flash request changed before done");
   chk_req_drop: assert property (flash_req && flash_done |=> !flash_req)
      else $error("flash request stayed after done");
   chk_sp_refuse: assert property ($rose(sp_mod_req) && wp_hit |=> sp_mod_refused && !sp_mod_grant)
      else $error("protected serial change not refused");
   chk_sp_grant: assert property ($rose(sp_mod_req) && !wp_hit && up_q == PUD_COUNT |=> sp_mod_grant && !sp_mod_refused)
      else $error("serial change not granted");
   chk_sp_cause: assert property (sp_mod_grant || sp_mod_refused |-> $past(sp_mod_req))
      else $error("serial answer without request");
   chk_reset_quiet: assert property ($rose(aresetn) |-> !flash_req && !sp_mod_grant && !sp_mod_refused)
      else $error("output active after reset");
   chk_data_high: assert property (s_axi_rvalid && ar_q == ADDR_DATA_HIGH |-> s_axi_rdata[31:6] == 26'h0)
      else $error("data high upper bits not zero");
   chk_key_zero: assert property (s_axi_rvalid && ar_q == ADDR_UNLOCK_KEY |-> s_axi_rdata == 32'h0)
      else $error("key port read not zero");
   cover property (flash_done && flash_op == PFW_OP_ERASE);
   cover property (flash_done && flash_op == PFW_OP_LATCH);
   cover property (sp_mod_refused);
endmodule

bind pfw_guard pfw_chk #(.PUD_COUNT(PUD_COUNT), .ADDR_W(ADDR_W)) pfw_chk_inst (.*);

/* bench/pfw_flash_model.sv */
// Purpose: flash array stand-in answering guard requests
// Assumes: request held until done
// Notes:   read word is {config select, address}
`timescale 1ns/1ps
module pfw_flash_model #(
   parameter int DLY = 3
) (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // guard side
   input wire logic        flash_req,
   input wire logic        flash_cfg,
   input wire logic [12:0] flash_addr,
   output logic            flash_done,
   output logic [13:0]     flash_rdata
);
   // ==========================================
   // answer timing
   logic [7:0]  cnt_q;
   logic [13:0] idle_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || !flash_req) begin
         cnt_q      <= 8'h00;
         flash_done <= 1'b0;
      end else begin
         flash_done <= (cnt_q == 8'(DLY));
         if (cnt_q <= 8'(DLY)) cnt_q <= cnt_q + 8'h01;
      end
   end
   // released bus repeats a word only every 16384 cycles
   always_ff @(posedge aclk) begin
      if (!aresetn) idle_q <= 14'h0000;
      else idle_q <= idle_q + 14'h1357;
   end
   assign flash_rdata = flash_done ? {flash_cfg, flash_addr} : idle_q;
endmodule

/* bench/tb.sv */
// Purpose: self-checking bench for the program flash write guard
// Assumes: shortened power-up delay
// Notes:   registers reached over AXI4-Lite
`timescale 1ns/1ps
module tb import pfw_pkg::*;;
   typedef struct packed {logic [7:0] setup; logic [7:0] fire; logic [1:0] op; logic [7:0] after;} pfw_row_t;
   localparam int PUD = 80;
   logic        aclk = 1'b0, aresetn = 1'b0, code_protect = 1'b0, wp_hit = 1'b0, sp_mod_req = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, flash_op, rsp, cap_op;
   logic        sp_mod_grant, sp_mod_refused, flash_req, flash_cfg, flash_done;
   logic [12:0] flash_addr, cap_ad;
   logic [13:0] flash_wdata, flash_rdata, cap_wd;
   int          bad_count = 0, total_checks = 0, cycles = 0, reqs = 0, n;
   pfw_row_t    rows [5] = '{'{8'h14, 8'h16, 2'h1, 8'h84}, '{8'h04, 8'h06, 2'h2, 8'h84},
                             '{8'h24, 8'h26, 2'h3, 8'hA4}, '{8'h40, 8'h41, 2'h0, 8'hC0},
                             '{8'h00, 8'h01, 2'h0, 8'h80}};
   pfw_guard #(.PUD_COUNT(PUD)) pfw_guard_inst (.*);
   pfw_flash_model #(.DLY(3)) pfw_flash_model_inst (.*);
   always #5 aclk = ~aclk;
   // ==========================================
   // monitor and timeout
   always @(posedge aclk) begin
      cycles++;
      if (flash_done === 1'b1) begin
         reqs++;
         cap_op = flash_op;
         cap_ad = flash_addr;
         cap_wd = flash_wdata;
      end
      if (cycles == 6000) begin
         bad_count++;
         stop_test();
      end
   end
   // ==========================================
   // tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         aw = aw | (s_axi_awready === 1'b1);
         w = w | (s_axi_wready === 1'b1);
         s_axi_awvalid <= !aw;
         s_axi_wvalid <= !w;
      end while (!(aw && w));
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic go(input logic [7:0] setup, input logic [7:0] k1, input logic [7:0] fire);
      wr(ADDR_CONTROL_1, {24'h0, setup});
      wr(ADDR_UNLOCK_KEY, {24'h0, k1});
      wr(ADDR_UNLOCK_KEY, {24'h0, KEY_SECOND ^ KEY_FIRST ^ k1});
      wr(ADDR_CONTROL_1, {24'h0, fire});
      rd_reg(ADDR_CONTROL_1);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(ADDR_CONTROL_1);
      check(rd, 32'h80);
      go(8'h04, KEY_FIRST, 8'h06);
      check(rd[1:0], 2'b00);
      rd_reg(ADDR_STATUS);
      check({rd[2], rd[0]}, 2'b11);
      do rd_reg(ADDR_STATUS); while (rd[0] !== 1'b0);
      code_protect <= 1'b1;
      wp_hit <= 1'b1;
      foreach (rows[i]) begin
         wr(ADDR_ADDR_LOW, 32'h5C);
         wr(ADDR_ADDR_HIGH, 32'h0A);
         wr(ADDR_DATA_LOW, 32'hC3);
         wr(ADDR_DATA_HIGH, 32'h2D);
         check(rsp, RESP_OKAY);
         n = reqs;
         go(rows[i].setup, KEY_FIRST, rows[i].fire);
         while (rd[1:0] !== 2'b00) rd_reg(ADDR_CONTROL_1);
         check(rd, {24'h0, rows[i].after});
         check(reqs, n + 1);
         check(cap_op, rows[i].op);
         check(cap_ad, 13'h0A5C);
         if (rows[i].op[1]) check(cap_wd, 14'h2DC3);
         if (rows[i].op == PFW_OP_READ) begin
            rd_reg(ADDR_DATA_HIGH);
            check(rd, {26'h0, rows[i].setup[6], 5'h0A});
            rd_reg(ADDR_DATA_LOW);
            check(rd, 32'h5C);
            check(rsp, RESP_OKAY);
         end
      end
      rd_reg(ADDR_STATUS);
      check(rd[3], 1'b1);
      n = reqs;
      go(8'h04, KEY_SECOND, 8'h06);
      check(rd[1:0], 2'b00);
      wr(ADDR_UNLOCK_KEY, 32'h55);
      wr(ADDR_DATA_LOW, 32'h00);
      go(8'h04, KEY_SECOND, 8'h06);
      check(rd[1:0], 2'b00);
      go(8'h00, KEY_FIRST, 8'h02);
      check(rd, 32'h80);
      rd_reg(ADDR_STATUS);
      check(rd[2], 1'b1);
      check(reqs, n);
      rd_reg(ADDR_UNLOCK_KEY);
      check(rd, 32'h0);
      wr(8'h1C, 32'h1);
      check(rsp, RESP_SLVERR);
      rd_reg(8'h1C);
      check(rsp, RESP_SLVERR);
      check(rd, 32'h0);
      for (int k = 0; k < 2; k++) begin
         wp_hit <= k[0];
         sp_mod_req <= 1'b1;
         @(posedge aclk);
         #1;
         check({sp_mod_grant, sp_mod_refused}, k[0] ? 2'b01 : 2'b10);
         @(posedge aclk);
         sp_mod_req <= 1'b0;
         @(posedge aclk);
      end
      wr(ADDR_CONTROL_1, 32'h04);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(ADDR_CONTROL_1);
      check(rd, 32'h80);
      rd_reg(ADDR_STATUS);
      check(rd[0], 1'b1);
      stop_test();
   end
endmodule
